/* File: bench/rcf_top_tb.sv */
// Purpose: self-checking bench for the reset-cause flag block
// Assumes: register port and cause levels driven at the rising edge
// Notes:   table rows cover single causes, hand tests cover the rest
`default_nettype none
module rcf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed
  {
    logic [7:0] cause;
    logic [7:0] pre0;
    logic [7:0] pre1;
    logic [7:0] exp0;
    logic [7:0] exp1;
  } rcf_row_s;
  localparam logic [8:0] P0 = rcf_pkg::OFS_POWER_CONTROL_0;
  localparam logic [8:0] P1 = rcf_pkg::OFS_POWER_CONTROL_1;
  localparam logic [8:0] BC = rcf_pkg::OFS_BROWNOUT_CONTROL;
  logic       clk_sys;
  logic       arst_n;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] cause;
  logic [1:0] bo_mode;
  logic       bo_rdy;
  logic       bo_en;
  logic [7:0] d;
  int         error_cnt;
  int         checks_done;
  // cause bits: wdt pin instr por bor mem_violation_flag push pop, from bit 0 up
  rcf_row_s   rows [8] = '{
    '{8'h01, 8'h1F, 8'h02, 8'h0F, 8'h02},
    '{8'h02, 8'h1F, 8'h02, 8'h17, 8'h02},
    '{8'h04, 8'h1F, 8'h02, 8'h1B, 8'h02},
    '{8'h20, 8'h1F, 8'h02, 8'h1F, 8'h00},
    '{8'h40, 8'h1F, 8'h02, 8'h9F, 8'h02},
    '{8'h80, 8'h1F, 8'h02, 8'h5F, 8'h02},
    '{8'h08, 8'hC3, 8'h00, 8'h1D, 8'h02},
    '{8'h10, 8'hC3, 8'h00, 8'h1E, 8'h02}};
  rcf_top rcf_top_inst
  (
    .CLK_SYS         (clk_sys),
    .ARST_N          (arst_n),
    .ADDR            (addr),
    .WDATA           (wdata),
    .WR              (wr),
    .RD              (rd),
    .RDATA           (rdata),
    .WDT_RESET       (cause[0]),
    .PIN_RESET       (cause[1]),
    .INSTR_RESET     (cause[2]),
    .POR_RESET       (cause[3]),
    .BOR_RESET       (cause[4]),
    .MEM_VIOLATION_FLAG_RESET      (cause[5]),
    .STACK_PUSH_FULL (cause[6]),
    .STACK_POP_EMPTY (cause[7]),
    .BO_MODE_CFG     (bo_mode),
    .BO_READY        (bo_rdy),
    .BO_ENABLE       (bo_en)
  );
  // 50 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [8:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask
  // cause levels held a few cycles then dropped
  task automatic pulse(input logic [7:0] c);
    @(posedge clk_sys);
    cause <= c;
    repeat (3) @(posedge clk_sys);
    cause <= 8'h00;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end
  // main sequence
  initial
  begin
    arst_n  = 1'b0;
    addr    = '0;
    wdata   = '0;
    wr      = 1'b0;
    rd      = 1'b0;
    cause   = '0;
    bo_mode = 2'h0;
    bo_rdy  = 1'b1;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    check("bo_enable in reset", {7'h00, bo_en}, 8'h01);
    repeat (3) @(posedge clk_sys);
    rd_reg(P0, d);
    check("power_control_0 reset", d, 8'h1D);
    rd_reg(P1, d);
    check("power_control_1 reset", d, 8'h02);
    rd_reg(BC, d);
    check("brownout_control reset", d, 8'h81);
    @(posedge clk_sys);
    #1;
    check("rdata idle", rdata, 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr_reg(P0, rows[i].pre0);
      wr_reg(P1, rows[i].pre1);
      pulse(rows[i].cause);
      rd_reg(P0, d);
      check("power_control_0 row", d, rows[i].exp0);
      rd_reg(P1, d);
      check("power_control_1 row", d, rows[i].exp1);
    end
    $display("test cause table done");
    wr_reg(P0, 8'hFF);
    rd_reg(P0, d);
    check("power_control_0 all ones", d, 8'hDF);
    wr_reg(P1, 8'hFF);
    rd_reg(P1, d);
    check("power_control_1 all ones", d, 8'h02);
    wr_reg(9'h18C, 8'hFF);
    rd_reg(9'h18C, d);
    check("unmapped", d, 8'h00);
    $display("test unused bits done");
    wr_reg(P0, 8'h1F);
    pulse(8'hC0);
    rd_reg(P0, d);
    check("stack both", d, 8'hDF);
    wr_reg(P1, 8'h00);
    wr_reg(P0, 8'h00);
    rd_reg(P0, d);
    check("power_control_0 cleared", d, 8'h00);
    repeat (5) @(posedge clk_sys);
    rd_reg(P0, d);
    check("stack stays zero", d, 8'h00);
    rd_reg(P1, d);
    check("power_control_1 no reset", d, 8'h00);
    check("bo_enable no reset", {7'h00, bo_en}, 8'h01);
    $display("test firmware write done");
    @(posedge clk_sys);
    cause <= 8'h01;
    wr_reg(P0, 8'hFF);
    cause <= 8'h00;
    rd_reg(P0, d);
    check("watchdog beats write", d, 8'hCF);
    @(posedge clk_sys);
    cause <= 8'h40;
    wr_reg(P0, 8'h00);
    cause <= 8'h00;
    rd_reg(P0, d);
    check("overflow beats write", d, 8'h80);
    $display("test precedence done");
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk_sys);
      bo_mode <= m[1:0];
      wr_reg(BC, 8'h00);
      repeat (2) @(posedge clk_sys);
      #1;
      check("bo_enable sw off", {7'h00, bo_en}, (m == 1) ? 8'h00 : 8'h01);
      wr_reg(BC, 8'h80);
      repeat (2) @(posedge clk_sys);
      #1;
      check("bo_enable sw on", {7'h00, bo_en}, 8'h01);
    end
    @(posedge clk_sys);
    bo_mode <= 2'h1;
    bo_rdy  <= 1'b0;
    wr_reg(BC, 8'h00);
    rd_reg(BC, d);
    check("brownout_control sw off", d, 8'h00);
    pulse(8'h08);
    #1;
    check("bo_enable after por", {7'h00, bo_en}, 8'h01);
    rd_reg(BC, d);
    check("brownout_control after por", d, 8'h80);
    $display("test brown-out enable done");
    wr_reg(P0, 8'h00);
    wr_reg(P1, 8'h00);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_reg(P0, d);
    check("power_control_0 after mid reset", d, 8'h1D);
    rd_reg(P1, d);
    check("power_control_1 after mid reset", d, 8'h02);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire

/* File: core/rcf_edge.sv */
// Purpose: turns cause levels into one-cycle events
// Assumes: cause inputs synchronous to the clock
// Notes:   a long level counts once
`default_nettype none
module rcf_edge
(
  input  wire logic       clk,   // system clock
  input  wire logic       rst_n, // synchronised reset
  input  wire logic [7:0] lvl,   // cause levels
  rcf_if.src              ev     // cause events
);
  typedef struct packed
  {
    logic [7:0] prev;
    logic [7:0] pulse;
  } rcf_edge_s;

  rcf_edge_s st;
  rcf_edge_s next_st;

  // rising edge detect
  always_comb
  begin
    next_st       = st;
    next_st.prev  = lvl;
    next_st.pulse = lvl & ~st.prev;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign ev.wdt   = st.pulse[0];
  assign ev.pin   = st.pulse[1];
  assign ev.instr = st.pulse[2];
  assign ev.por   = st.pulse[3];
  assign ev.bor   = st.pulse[4];
  assign ev.mem_violation_flag  = st.pulse[5];
  assign ev.ovf   = st.pulse[6];
  assign ev.unf   = st.pulse[7];
endmodule
`default_nettype wire

/* File: core/rcf_if.sv */
// Purpose: cause events from the edge stage to the flag register
// Assumes: one clock domain
// Notes:   each event is a one-cycle pulse
`default_nettype none
interface rcf_if;
  logic wdt;
  logic pin;
  logic instr;
  logic por;
  logic bor;
  logic mem_violation_flag;
  logic ovf;
  logic unf;
  modport src (output wdt, pin, instr, por, bor, mem_violation_flag, ovf, unf);
  modport dst (input wdt, pin, instr, por, bor, mem_violation_flag, ovf, unf);
endinterface
`default_nettype wire

/* File: core/rcf_pkg.sv */
// Purpose: shared constants for the reset-cause flag block
// Assumes: 8-bit registers on a plain strobe port, 9-bit word address
// Notes:   offsets are register addresses, one register per address
`default_nettype none
package rcf_pkg;
  localparam int unsigned AW = 9;
  localparam logic [8:0] OFS_BROWNOUT_CONTROL = 9'h18D;
  localparam logic [8:0] OFS_POWER_CONTROL_0  = 9'h18E;
  localparam logic [8:0] OFS_POWER_CONTROL_1  = 9'h18F;
  // power_control_0 field positions
  localparam int unsigned BIT_STACK_OVER  = 7;
  localparam int unsigned BIT_STACK_UNDER = 6;
  localparam int unsigned BIT_WATCHDOG    = 4;
  localparam int unsigned BIT_PIN         = 3;
  localparam int unsigned BIT_INSTR       = 2;
  localparam int unsigned BIT_POWERON     = 1;
  localparam int unsigned BIT_BROWNOUT    = 0;
  // power_control_1 and brownout_control field positions
  localparam int unsigned BIT_MEM_VIOL    = 1;
  localparam int unsigned BIT_SW_BO_EN    = 7;
  localparam int unsigned BIT_BO_READY    = 0;
  // implemented bits
  localparam logic [7:0] MASK_POWER_CONTROL_0 = 8'hDF;
  localparam logic [7:0] MASK_POWER_CONTROL_1 = 8'h02;
  // reset values, and the brown-out mode code that selects the software enable
  localparam logic       RST_SW_BO_EN = 1'h1;
  localparam logic [7:0] RST_POWER_CONTROL_0    = 8'h1D;
  localparam logic [7:0] RST_POWER_CONTROL_1    = 8'h02;
  localparam logic [1:0] BO_MODE_SW   = 2'h1;
endpackage
`default_nettype wire

/* File: core/rcf_top.sv */
// Purpose: reset-cause flag registers with brown-out control
// Assumes: 50 MHz CLK_SYS, strobe register port, read data next cycle
// Notes:   cause inputs are levels; each rising edge is one event
`default_nettype none
module rcf_top
(
  input  wire logic       CLK_SYS,       // 50 MHz system clock
  input  wire logic       ARST_N,        // async reset, active low
  input  wire logic [8:0] ADDR,          // register address
  input  wire logic [7:0] WDATA,         // write data
  input  wire logic       WR,            // write strobe
  input  wire logic       RD,            // read strobe
  output logic      [7:0] RDATA,         // read data, cycle after RD
  input  wire logic       WDT_RESET,     // watchdog time-out reset
  input  wire logic       PIN_RESET,     // master-clear pin reset
  input  wire logic       INSTR_RESET,   // reset instruction executed
  input  wire logic       POR_RESET,     // power-on reset
  input  wire logic       BOR_RESET,     // brown-out reset
  input  wire logic       MEM_VIOLATION_FLAG_RESET,    // memory execution violation
  input  wire logic       STACK_PUSH_FULL, // call pushed on full stack
  input  wire logic       STACK_POP_EMPTY, // return on empty stack
  input  wire logic [1:0] BO_MODE_CFG,   // brown-out configuration field
  input  wire logic       BO_READY,      // brown-out circuit ready
  output logic            BO_ENABLE      // brown-out detector enable
);
  logic [1:0] rst_sync;
  logic       rst_n;

  ////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////
  // cause events
  rcf_if ev ();

  rcf_edge rcf_edge_inst
  (
    .clk   (CLK_SYS),
    .rst_n (rst_n),
    .lvl   ({STACK_POP_EMPTY, STACK_PUSH_FULL, MEM_VIOLATION_FLAG_RESET, BOR_RESET,
             POR_RESET, INSTR_RESET, PIN_RESET, WDT_RESET}),
    .ev    (ev)
  );

  ////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed
  {
    logic [7:0] power_control_0;
    logic [7:0] power_control_1;
    logic       sw_brownout_enable;
    logic       bo_enable;
    logic [7:0] rdata;
  } rcf_top_s;

  rcf_top_s st;
  rcf_top_s next_st;

  // decode a write to one register
  function automatic logic wr_hit(input logic w, input logic [8:0] a, input logic [8:0] o);
    wr_hit = w && (a == o);
  endfunction

  logic       any_pbor;
  logic [7:0] wr0;
  logic [7:0] wr1;
  logic       wr_p0;
  logic       wr_p1;
  logic       any_ev;

  // firmware writes apply first, hardware events then override
  always_comb
  begin
    next_st  = st;
    any_pbor = ev.por | ev.bor;
    wr0      = WDATA & rcf_pkg::MASK_POWER_CONTROL_0;
    wr1      = WDATA & rcf_pkg::MASK_POWER_CONTROL_1;
    wr_p0    = wr_hit(WR, ADDR, rcf_pkg::OFS_POWER_CONTROL_0);
    wr_p1    = wr_hit(WR, ADDR, rcf_pkg::OFS_POWER_CONTROL_1);
    any_ev   = any_pbor | ev.wdt | ev.pin | ev.instr | ev.mem_violation_flag | ev.ovf | ev.unf;
    // firmware stores value only, no reset action
    if (wr_p0)
      next_st.power_control_0 = wr0;
    if (wr_p1)
      next_st.power_control_1 = wr1;
    if (wr_hit(WR, ADDR, rcf_pkg::OFS_BROWNOUT_CONTROL))
      next_st.sw_brownout_enable = WDATA[rcf_pkg::BIT_SW_BO_EN];
    // stack faults set only
    if (ev.ovf)
      next_st.power_control_0[rcf_pkg::BIT_STACK_OVER] = 1'b1;
    if (ev.unf)
      next_st.power_control_0[rcf_pkg::BIT_STACK_UNDER] = 1'b1;
    // each cause clears only its own flag
    if (ev.wdt)
      next_st.power_control_0[rcf_pkg::BIT_WATCHDOG] = 1'b0;
    if (ev.pin)
      next_st.power_control_0[rcf_pkg::BIT_PIN] = 1'b0;
    if (ev.instr)
      next_st.power_control_0[rcf_pkg::BIT_INSTR] = 1'b0;
    if (ev.mem_violation_flag)
      next_st.power_control_1[rcf_pkg::BIT_MEM_VIOL] = 1'b0;
    // power-on / brown-out initialisation, others keep bits
    if (any_pbor)
    begin
      next_st.power_control_0[rcf_pkg::BIT_STACK_OVER]  = 1'b0;
      next_st.power_control_0[rcf_pkg::BIT_STACK_UNDER] = 1'b0;
      next_st.power_control_0[rcf_pkg::BIT_WATCHDOG]    = 1'b1;
      next_st.power_control_0[rcf_pkg::BIT_PIN]         = 1'b1;
      next_st.power_control_0[rcf_pkg::BIT_INSTR]       = 1'b1;
      next_st.power_control_0[rcf_pkg::BIT_POWERON]     = !ev.por ? st.power_control_0[rcf_pkg::BIT_POWERON]
                                                       : 1'b0;
      next_st.power_control_0[rcf_pkg::BIT_BROWNOUT]    = !ev.bor;
      if (ev.bor)
        next_st.power_control_0[rcf_pkg::BIT_POWERON] = st.power_control_0[rcf_pkg::BIT_POWERON] & ~ev.por;
      next_st.power_control_1[rcf_pkg::BIT_MEM_VIOL]    = 1'b1;
      next_st.sw_brownout_enable              = rcf_pkg::RST_SW_BO_EN;
    end
    // software enable matters only in mode 01
    next_st.bo_enable = (BO_MODE_CFG == rcf_pkg::BO_MODE_SW) ? st.sw_brownout_enable
                                                              : 1'b1;
    // read path, unmapped reads zero
    next_st.rdata = 8'h00;
    if (RD)
    begin
      case (ADDR)
        rcf_pkg::OFS_BROWNOUT_CONTROL:
          next_st.rdata = {st.sw_brownout_enable, 6'h00, BO_READY};
        rcf_pkg::OFS_POWER_CONTROL_0:
          next_st.rdata = st.power_control_0 & rcf_pkg::MASK_POWER_CONTROL_0;
        rcf_pkg::OFS_POWER_CONTROL_1:
          next_st.rdata = st.power_control_1 & rcf_pkg::MASK_POWER_CONTROL_1;
        default:
          next_st.rdata = 8'h00;
      endcase
    end
  end

  // state register; power-up state is that of a power-on reset
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st                    <= '0;
      st.power_control_0              <= rcf_pkg::RST_POWER_CONTROL_0;
      st.power_control_1              <= rcf_pkg::RST_POWER_CONTROL_1;
      st.sw_brownout_enable <= rcf_pkg::RST_SW_BO_EN;
      st.bo_enable          <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign RDATA     = st.rdata;
  assign BO_ENABLE = st.bo_enable;

  ////////////////////////////////////////////////////////////////////
  // checks
  chk_ovf_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.ovf && !any_pbor |=> st.power_control_0[rcf_pkg::BIT_STACK_OVER])
    else $error("overflow flag not set");
  chk_unf_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.unf && !any_pbor |=> st.power_control_0[rcf_pkg::BIT_STACK_UNDER])
    else $error("underflow flag not set");
  chk_stack_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    $rose(st.power_control_0[rcf_pkg::BIT_STACK_OVER]) |-> $past(ev.ovf) || $past(wr_p0))
    else $error("overflow flag rose without cause");
  chk_wdt_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.wdt && !any_pbor |=> !st.power_control_0[rcf_pkg::BIT_WATCHDOG])
    else $error("watchdog flag not cleared");
  chk_pin_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.pin && !any_pbor |=> !st.power_control_0[rcf_pkg::BIT_PIN])
    else $error("pin flag not cleared");
  chk_instr_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.instr && !any_pbor |=> !st.power_control_0[rcf_pkg::BIT_INSTR])
    else $error("instruction flag not cleared");
  chk_por_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.por |=> !st.power_control_0[rcf_pkg::BIT_POWERON])
    else $error("power-on status not cleared");
  chk_bor_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.bor |=> !st.power_control_0[rcf_pkg::BIT_BROWNOUT])
    else $error("brown-out status not cleared");
  chk_mem_violation_flag_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.mem_violation_flag && !any_pbor |=> !st.power_control_1[rcf_pkg::BIT_MEM_VIOL])
    else $error("violation flag not cleared");
  chk_pbor_init: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    any_pbor |=> st.power_control_0[7:6] == 2'h0 && st.power_control_0[4:2] == 3'h7)
    else $error("cause flags not initialised");
  chk_keep_por: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !any_pbor && !WR |=> $stable(st.power_control_0[1:0]))
    else $error("power bits changed by other reset");
  chk_rsvd_zero: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    RD && ADDR == rcf_pkg::OFS_POWER_CONTROL_0 |=> RDATA[5] == 1'b0)
    else $error("reserved bit reads nonzero");
  chk_sw_enable: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    BO_MODE_CFG != rcf_pkg::BO_MODE_SW |=> BO_ENABLE)
    else $error("enable gated outside mode 01");

  ////////////////////////////////////////////////////////////////////
  // further checks: precedence, isolation, storage
  // underflow flag rises only on a fault or a firmware write
  chk_unf_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    $rose(st.power_control_0[rcf_pkg::BIT_STACK_UNDER]) |-> $past(ev.unf) || $past(wr_p0))
    else $error("underflow flag rose without cause");

  // a cause event beats a firmware write landing in the same cycle
  chk_ovf_wins: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.ovf && wr_p0 && !any_pbor |=> st.power_control_0[rcf_pkg::BIT_STACK_OVER])
    else $error("overflow lost to firmware write");
  chk_unf_wins: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.unf && wr_p0 && !any_pbor |=> st.power_control_0[rcf_pkg::BIT_STACK_UNDER])
    else $error("underflow lost to firmware write");
  chk_wdt_wins: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.wdt && wr_p0 && !any_pbor |=> !st.power_control_0[rcf_pkg::BIT_WATCHDOG])
    else $error("watchdog clear lost to firmware write");
  chk_pin_wins: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.pin && wr_p0 && !any_pbor |=> !st.power_control_0[rcf_pkg::BIT_PIN])
    else $error("pin clear lost to firmware write");
  chk_mem_violation_flag_wins: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.mem_violation_flag && wr_p1 && !any_pbor |=> !st.power_control_1[rcf_pkg::BIT_MEM_VIOL])
    else $error("violation clear lost to firmware write");

  // a lone cause leaves the other cause flags alone
  chk_wdt_only: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.wdt && !ev.pin && !ev.instr && !any_pbor && !wr_p0 |=>
      $stable(st.power_control_0[3:0]))
    else $error("watchdog cause touched other flags");
  chk_pin_only: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.pin && !ev.wdt && !ev.instr && !any_pbor && !wr_p0 |=>
      $stable(st.power_control_0[4]) && $stable(st.power_control_0[2:0]))
    else $error("pin cause touched other flags");
  chk_instr_only: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.instr && !ev.wdt && !ev.pin && !any_pbor && !wr_p0 |=>
      $stable(st.power_control_0[4:3]) && $stable(st.power_control_0[1:0]))
    else $error("instruction cause touched other flags");
  chk_mem_violation_flag_only: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.mem_violation_flag && !ev.wdt && !ev.pin && !ev.instr && !any_pbor && !wr_p0 |=>
      $stable(st.power_control_0[4:0]))
    else $error("violation cause touched other flags");

  // power-on / brown-out initialisation of the remaining bits
  chk_por_bo_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    ev.por && !ev.bor |=> st.power_control_0[rcf_pkg::BIT_BROWNOUT])
    else $error("brown-out status not set on power-on");
  chk_pbor_mem_violation_flag: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    any_pbor |=> st.power_control_1[rcf_pkg::BIT_MEM_VIOL])
    else $error("violation flag not initialised");
  chk_pbor_swen: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    any_pbor |=> st.sw_brownout_enable)
    else $error("software enable not initialised");

  // firmware writes store the value and start nothing
  chk_wr_p0_store: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    wr_p0 && !any_ev |=>
      st.power_control_0 == ($past(WDATA) & rcf_pkg::MASK_POWER_CONTROL_0))
    else $error("power_control_0 write not stored");
  chk_wr_p1_store: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    wr_p1 && !any_pbor && !ev.mem_violation_flag |=>
      st.power_control_1 == ($past(WDATA) & rcf_pkg::MASK_POWER_CONTROL_1))
    else $error("power_control_1 write not stored");
  chk_wr_no_reset: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    wr_p0 && !any_pbor && !ev.mem_violation_flag |=> $stable(st.power_control_1) && $stable(st.sw_brownout_enable))
    else $error("firmware write started a reset action");

  // unimplemented bits stay zero in storage and on reads
  chk_rsvd_store: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (st.power_control_0 & ~rcf_pkg::MASK_POWER_CONTROL_0) == 8'h00 &&
      (st.power_control_1 & ~rcf_pkg::MASK_POWER_CONTROL_1) == 8'h00)
    else $error("unimplemented bit stored");
  chk_p1_rsvd_rd: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    RD && ADDR == rcf_pkg::OFS_POWER_CONTROL_1 |=> (RDATA & ~rcf_pkg::MASK_POWER_CONTROL_1) == 8'h00)
    else $error("unimplemented bit of power_control_1 reads nonzero");
  chk_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    !RD |=> RDATA == 8'h00)
    else $error("read data nonzero without read");

  // enable follows the software bit in mode 01
  chk_sw_follow: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    BO_MODE_CFG == rcf_pkg::BO_MODE_SW |=> BO_ENABLE == $past(st.sw_brownout_enable))
    else $error("enable does not follow software bit");
endmodule
`default_nettype wire
